// ===== hw/ebm_mapper.sv
// Purpose: host bus to 8-bit ethernet controller address mapper
// Assumes: host holds address, direction and data steady until acknowledge
// Notes:   one controller access per host cycle, fixed wait before acknowledge
//
// What this block does
// - the ethernet region is decoded at base 0x40000000 of the host bus.
// - the controller register block starts at region base plus 0x300.
// - even registers are reached at their plain address with the byte on the low lane.
// - odd registers are reached at the even address below plus 0x8000.
// - odd register bytes are also returned on the low lane.
// - the controller interrupt drives the host level three interrupt request.
// - the region spans one megabyte and needs the third chip select.
// - the mapper drives transfer acknowledge for every region cycle itself.
`timescale 1ns/1ps
`default_nettype none
module ebm_mapper #(
  parameter int ACK_WAIT = ebm_pkg::ACK_WAIT
) (
  input  wire logic                      sys_clk_i,
  input  wire logic                      arst_n_i,
  input  wire logic                      transfer_start_n_i,
  input  wire logic                      ethernet_region_select_n_i,
  input  wire ebm_pkg::ebm_req_t         host_req_i,
  output logic [15:0]                    host_rdata_o,
  output logic                           host_rdata_oe_o,
  output logic                           transfer_acknowledge_n_o,
  output logic                           transfer_acknowledge_oe_o,
  output ebm_pkg::ebm_ctl_t              chip_ctl_o,
  input  wire logic [7:0]                chip_rdata_i,
  input  wire logic                      chip_irq_i,
  output logic                           level_three_interrupt_request_n_o
);
  if (ACK_WAIT < 1 || ACK_WAIT > 15) begin
    $error("ACK_WAIT out of range");
  end
  localparam int REG_IDX_HI = ebm_pkg::REG_AW - 1;

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  logic [1:0] ts_sync;
  logic [1:0] cs_sync;
  logic [1:0] irq_sync;
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ts_sync  <= 2'b11;
      cs_sync  <= 2'b11;
      irq_sync <= 2'b00;
    end else begin
      ts_sync  <= {ts_sync[0], transfer_start_n_i};
      cs_sync  <= {cs_sync[0], ethernet_region_select_n_i};
      irq_sync <= {irq_sync[0], chip_irq_i};
    end
  end
  wire logic ts_seen  = !ts_sync[1];
  wire logic cs_seen  = !cs_sync[1];

  // ************************************************************
  // address decode
  // ************************************************************
  logic [31:0] addr;
  logic        in_region;
  logic        odd_reg;
  logic [31:0] reg_off;
  logic        hit;
  always_comb begin
    addr      = host_req_i.addr;
    in_region = (addr >= ebm_pkg::REGION_BASE) && (addr <= ebm_pkg::REGION_LAST);
    odd_reg   = (addr & ebm_pkg::ODD_ALIAS) != 32'h0000_0000;
    reg_off   = (addr & ~ebm_pkg::ODD_ALIAS) - ebm_pkg::CHIP_BASE;
    hit       = in_region && (addr[0] == 1'b0) &&
                (addr >= ebm_pkg::CHIP_BASE) && ((reg_off >> ebm_pkg::REG_AW) == 32'h0000_0000);
  end

  // ************************************************************
  // cycle sequencer
  // ************************************************************
  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_ACK, ST_END} ebm_state_t;
  ebm_state_t  state;
  logic [3:0]  wait_cnt;
  logic [15:0] rdata;
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state    <= ST_IDLE;
      wait_cnt <= 4'h0;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (ts_seen && cs_seen && in_region) begin
            state    <= ST_WAIT;
            wait_cnt <= 4'(ACK_WAIT - 1);
          end
        end
        ST_WAIT: begin
          if (wait_cnt == 4'h0) begin
            state <= ST_ACK;
          end else begin
            wait_cnt <= wait_cnt - 4'h1;
          end
        end
        ST_ACK: begin
          state <= ST_END;
        end
        ST_END: begin
          if (!ts_seen) begin
            state <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // ************************************************************
  // controller strobe and read capture
  // ************************************************************
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      chip_ctl_o <= '0;
    end else if (state == ST_IDLE && ts_seen && cs_seen && hit) begin
      chip_ctl_o.valid   <= 1'b1;
      chip_ctl_o.write   <= !host_req_i.rd_n;
      chip_ctl_o.reg_idx <= {reg_off[REG_IDX_HI:1], odd_reg};
      chip_ctl_o.wbyte   <= host_req_i.wdata[7:0];
    end else if (state == ST_ACK) begin
      chip_ctl_o.valid <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata <= 16'h0000;
    end else if (state == ST_WAIT && wait_cnt == 4'h0) begin
      rdata <= {ebm_pkg::ZERO_BYTE, chip_ctl_o.valid ? chip_rdata_i : ebm_pkg::ZERO_BYTE};
    end
  end

  // ************************************************************
  // host answer
  // ************************************************************
  always_comb begin
    host_rdata_o              = rdata;
    host_rdata_oe_o           = (state == ST_ACK) && host_req_i.rd_n;
    transfer_acknowledge_n_o  = !(state == ST_ACK);
    transfer_acknowledge_oe_o = (state == ST_ACK) || (state == ST_END);
    level_three_interrupt_request_n_o = !irq_sync[1];
  end

  // ************************************************************
  // checks
  // ************************************************************
  AST_ACK_ONE: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    !transfer_acknowledge_n_o |=> transfer_acknowledge_n_o)
    else $error("acknowledge longer than one cycle");
  AST_ACK_DELAY: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    (state == ST_IDLE && ts_seen && cs_seen && in_region) |-> ##[1:16] !transfer_acknowledge_n_o)
    else $error("acknowledge missing");
  AST_NO_SELECT: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    (state == ST_IDLE && !cs_seen) |=> state == ST_IDLE)
    else $error("cycle started without chip select");
  AST_UPPER_ZERO: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    host_rdata_oe_o |-> host_rdata_o[15:8] == 8'h00)
    else $error("upper lane not zero");
  AST_LOW_LANE: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    (state == ST_WAIT && wait_cnt == 4'h0 && chip_ctl_o.valid) |=>
      rdata[7:0] == $past(chip_rdata_i))
    else $error("register byte not on low lane");
  AST_IRQ_PASS: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    $rose(irq_sync[1]) |-> !level_three_interrupt_request_n_o)
    else $error("interrupt not forwarded");
  AST_ODD_IDX: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    (state == ST_IDLE && ts_seen && cs_seen && hit && odd_reg) |=> chip_ctl_o.reg_idx[0])
    else $error("odd alias not mapped to odd register");
  AST_EVEN_IDX: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    (state == ST_IDLE && ts_seen && cs_seen && hit && !odd_reg) |=> !chip_ctl_o.reg_idx[0])
    else $error("even address not mapped to even register");
  AST_BASE: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    (state == ST_IDLE && ts_seen && cs_seen && host_req_i.addr == ebm_pkg::CHIP_BASE) |=>
      chip_ctl_o.valid && chip_ctl_o.reg_idx == 5'h00)
    else $error("register block base wrong");

  // ************************************************************
  // handshake and strobe checks
  // ************************************************************
  wire logic take_hit = (state == ST_IDLE) && ts_seen && cs_seen && hit;
  AST_ACK_OE: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    !transfer_acknowledge_n_o |-> transfer_acknowledge_oe_o)
    else $error("acknowledge not driven");
  AST_RDOE_ACK: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    host_rdata_oe_o |-> !transfer_acknowledge_n_o)
    else $error("read data driven outside acknowledge");
  AST_ACK_ENDS: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    !transfer_acknowledge_n_o |=> transfer_acknowledge_oe_o && !chip_ctl_o.valid)
    else $error("cycle not closed after acknowledge");
  AST_WAIT_BOUND: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    (state == ST_WAIT) |-> wait_cnt < 4'(ACK_WAIT))
    else $error("wait count out of range");
  AST_OUTSIDE: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    (state == ST_IDLE && !in_region) |=> state == ST_IDLE)
    else $error("cycle started outside region");
  AST_MISS_NO_STROBE: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    (state == ST_IDLE && ts_seen && cs_seen && in_region && !hit) |=> !chip_ctl_o.valid)
    else $error("strobe for address outside register block");
  AST_SELECT_TAKE: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    $rose(chip_ctl_o.valid) |-> $past(cs_seen) && $past(ts_seen))
    else $error("strobe without chip select");
  AST_CTL_STABLE: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    (chip_ctl_o.valid && state != ST_ACK) |=>
      $stable(chip_ctl_o.reg_idx) && $stable(chip_ctl_o.write))
    else $error("controller request changed while open");
  AST_WBYTE: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    (take_hit && !host_req_i.rd_n) |=>
      chip_ctl_o.write && chip_ctl_o.wbyte == $past(host_req_i.wdata[7:0]))
    else $error("write byte not from low lane");
  AST_MISS_ZERO: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    (state == ST_WAIT && wait_cnt == 4'h0 && !chip_ctl_o.valid) |=> rdata == 16'h0000)
    else $error("non register read not zero");
  AST_END_HOLD: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    (state == ST_END && ts_seen) |=> state == ST_END)
    else $error("cycle closed before transfer start released");
  AST_IRQ_FALL: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    $fell(irq_sync[1]) |-> level_three_interrupt_request_n_o)
    else $error("interrupt not released");
endmodule
`default_nettype wire

// ===== hw/ebm_pkg.sv
// Purpose: constants and carriers for the ethernet bus address mapper
// Assumes: 32-bit host address, 16-bit host data, 8-bit controller bus
// Notes:   none
package ebm_pkg;
  localparam logic [31:0] REGION_BASE  = 32'h4000_0000;
  localparam logic [31:0] REGION_LAST  = 32'h400F_FFFF;
  localparam logic [31:0] IO_BASE      = 32'h0000_0300;
  localparam logic [31:0] CHIP_BASE    = 32'h4000_0300;
  localparam logic [31:0] ODD_ALIAS    = 32'h0000_8000;
  localparam int          REG_AW       = 5;
  localparam int          ACK_WAIT     = 2;
  localparam logic [7:0]  ZERO_BYTE    = 8'h00;

  typedef struct packed {
    logic        rd_n;
    logic [31:0] addr;
    logic [15:0] wdata;
  } ebm_req_t;

  typedef struct packed {
    logic             valid;
    logic             write;
    logic [REG_AW-1:0] reg_idx;
    logic [7:0]       wbyte;
  } ebm_ctl_t;
endpackage

// ===== dv/ebm_host_model.sv
// Purpose: host bus master model for the ethernet bus address mapper
// Assumes: word transfers, cycle held open until acknowledge or 24 edges
// Notes:   released request lines show inverted values, never stale ones
`timescale 1ns/1ps
`default_nettype none
module ebm_host_model (
  input  wire logic          sys_clk_i,
  input  wire logic          transfer_acknowledge_n_i,
  input  wire logic [15:0]   host_rdata_i,
  output logic               transfer_start_n_o,
  output logic               ethernet_region_select_n_o,
  output ebm_pkg::ebm_req_t  host_req_o
);
  initial begin
    transfer_start_n_o = 1'b1;
    ethernet_region_select_n_o = 1'b1;
    host_req_o = '0;
  end

  // one word cycle; gives up after 24 edges without acknowledge
  task automatic xfer(input logic cs_n, input logic rd_n, input logic [31:0] addr,
                      input logic [15:0] wdata, output logic acked, output logic [15:0] rdata);
    int n;
    acked = 1'b0;
    rdata = 16'h0000;
    @(posedge sys_clk_i);
    transfer_start_n_o <= 1'b0;
    ethernet_region_select_n_o <= cs_n;
    host_req_o <= {rd_n, addr, wdata};
    for (n = 0; n < 24 && !acked; n++) begin
      @(posedge sys_clk_i);
      if (transfer_acknowledge_n_i === 1'b0) begin
        acked = 1'b1;
        rdata = host_rdata_i;
      end
    end
    transfer_start_n_o <= 1'b1;
    ethernet_region_select_n_o <= 1'b1;
    host_req_o <= ~host_req_o;
    repeat (4) @(posedge sys_clk_i);
  endtask
endmodule
`default_nettype wire

// ===== dv/ebm_mapper_tb_top.sv
// Purpose: self-checking bench for the ethernet bus address mapper
// Assumes: controller modelled as a 32-byte register file
// Notes:   acknowledge wait raised to 4 for read data margin
`timescale 1ns/1ps
`default_nettype none
module ebm_mapper_tb_top;
  logic sys_clk_i = 1'b0, arst_n_i = 1'b0, chip_irq = 1'b0, ts_n, cs_n, ack_n, irq_n, ack, wr;
  logic ack_oe, rd_oe, vq, ack_oe_q, rd_oe_q;
  logic [7:0] chip_rdata = 8'h00, regs [32], wbyte;
  logic [15:0] rdata, rd;
  logic [4:0] idx;
  logic [31:0] seed = 32'hdfe7_2106, hits = 32'h0000_0000, h0;
  logic [31:0] r_addr [6] = '{32'h4000_0000, 32'h4000_0301, 32'h4000_0320, 32'h400F_FFFE,
                              32'h4010_0000, 32'h3FFF_FFFE};
  ebm_pkg::ebm_req_t req;
  ebm_pkg::ebm_ctl_t ctl;
  int mismatches = 0, samples_checked = 0, i;

  always #2 sys_clk_i = ~sys_clk_i;

  ebm_mapper #(.ACK_WAIT(4)) i_ebm_mapper (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i),
    .transfer_start_n_i(ts_n), .ethernet_region_select_n_i(cs_n), .host_req_i(req),
    .host_rdata_o(rdata), .host_rdata_oe_o(rd_oe), .transfer_acknowledge_n_o(ack_n),
    .transfer_acknowledge_oe_o(ack_oe), .chip_ctl_o(ctl), .chip_rdata_i(chip_rdata),
    .chip_irq_i(chip_irq), .level_three_interrupt_request_n_o(irq_n));
  ebm_host_model i_ebm_host_model (.sys_clk_i(sys_clk_i), .transfer_acknowledge_n_i(ack_n),
    .host_rdata_i(rdata), .transfer_start_n_o(ts_n), .ethernet_region_select_n_o(cs_n),
    .host_req_o(req));

  // controller side: register file and strobe monitor
  always @(posedge sys_clk_i) begin
    chip_rdata <= regs[ctl.reg_idx];
    vq <= ctl.valid;
    if (ack_n === 1'b0) begin
      ack_oe_q <= ack_oe;
      rd_oe_q <= rd_oe;
    end
    if (ctl.valid === 1'b1 && vq !== 1'b1) begin
      idx <= ctl.reg_idx;
      wr <= ctl.write;
      wbyte <= ctl.wbyte;
      hits <= hits + 1;
    end
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [31:0] reg_addr(input int n);
    return ebm_pkg::CHIP_BASE + 32'(n & ~1) + ((n & 1) ? ebm_pkg::ODD_ALIAS : 32'h0000_0000);
  endfunction

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge sys_clk_i);
    mismatches++;
    stop_test();
  end

  initial begin
    for (i = 0; i < 32; i++) begin
      seed = lfsr(seed);
      regs[i] = seed[7:0];
    end
    repeat (4) @(posedge sys_clk_i);
    arst_n_i <= 1'b1;
    check("reset", {11'h000, ack_n, ack_oe, rd_oe, irq_n, ctl.valid}, 16'h0012);
    check("reset data", rdata, 16'h0000);
    for (i = 0; i < 32; i++) begin
      seed = lfsr(seed);
      h0 = hits;
      i_ebm_host_model.xfer(1'b0, 1'b1, reg_addr(i), seed[31:16], ack, rd);
      check("read ack", {15'h0000, ack}, 16'h0001);
      check("read data", rd, {8'h00, regs[i]});
      check("read reg", {11'h000, idx}, 16'(i));
      check("read oe", {14'h0000, ack_oe_q, rd_oe_q}, 16'h0003);
      i_ebm_host_model.xfer(1'b0, 1'b0, reg_addr(i), seed[15:0], ack, rd);
      check("write", {2'b00, wr, idx, wbyte}, {3'b001, 5'(i), seed[7:0]});
      check("write oe", {14'h0000, ack_oe_q, rd_oe_q}, 16'h0002);
      check("strobes", hits[15:0] - h0[15:0], 16'h0002);
    end
    for (i = 0; i < 7; i++) begin
      h0 = hits;
      i_ebm_host_model.xfer(i == 6, 1'b1, (i == 6) ? 32'h4000_0300 : r_addr[i], 16'h0000, ack, rd);
      check("ack in region", {15'h0000, ack}, {15'h0000, i < 4});
      check("refused data", rd, 16'h0000);
      check("no strobe", hits[15:0], h0[15:0]);
    end
    for (i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      chip_irq <= (i < 2) ? i[0] : seed[5];
      repeat (5) @(posedge sys_clk_i);
      check("irq", {15'h0000, irq_n}, {15'h0000, ~chip_irq});
    end
    stop_test();
  end
endmodule
`default_nettype wire
